/* File: design/csbc_bit_unit.sv */
// Combinational bit and carry operator of the stack and bit core
`timescale 1ns/10ps
`include "csbc_regs.svh"

module csbc_bit_unit (
  input wire csbc_pkg::csbc_op_e op_i,
  input wire logic [7:0] byte_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic carry_i,
  output logic [7:0] byte_o,
  output logic carry_o
);

  logic bit_val;

  always_comb begin
    bit_val = byte_i[bit_sel_i];
    byte_o = byte_i;
    carry_o = carry_i;
    unique case (op_i)
      csbc_pkg::CSBC_MOVE_OP_C_BIT: carry_o = bit_val;
      csbc_pkg::CSBC_MOVE_OP_BIT_C: byte_o[bit_sel_i] = carry_i;
      csbc_pkg::CSBC_CLEAR_OP_C: carry_o = 1'b0;
      csbc_pkg::CSBC_CLEAR_OP_BIT: byte_o[bit_sel_i] = 1'b0;
      csbc_pkg::CSBC_SET_BIT_OP_C: carry_o = 1'b1;
      csbc_pkg::CSBC_SET_BIT_OP_BIT: byte_o[bit_sel_i] = 1'b1;
      csbc_pkg::CSBC_COMPLEMENT_OP_C: carry_o = ~carry_i;
      csbc_pkg::CSBC_COMPLEMENT_OP_BIT: byte_o[bit_sel_i] = ~bit_val;
      csbc_pkg::CSBC_AND_LOGIC_OP_BIT: carry_o = carry_i & bit_val;
      csbc_pkg::CSBC_AND_LOGIC_OP_NBIT: carry_o = carry_i & ~bit_val;
      csbc_pkg::CSBC_OR_LOGIC_OP_BIT: carry_o = carry_i | bit_val;
      csbc_pkg::CSBC_OR_LOGIC_OP_NBIT: carry_o = carry_i | ~bit_val;
      default: begin
        byte_o = byte_i;
        carry_o = carry_i;
      end
    endcase
  end

endmodule

/* File: design/csbc_core.sv */
// Stack, idle and carry bit engine with the core special function registers
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "csbc_regs.svh"

// Functional notes
// - A push increments the stack pointer first, then writes the direct byte at the new top, in 2 cycles.
// - A pop copies the byte at the stack top to the direct address, then decrements the pointer.
// - The idle operation changes nothing and finishes in one cycle.
// - Bit move copies an addressable bit into carry or carry into an addressable bit.
// - Clear forces carry (one cycle) or an addressable bit (two cycles) to zero.
// - Set forces carry (one cycle) or an addressable bit (two cycles) to one.
// - Complement inverts carry or an addressable bit; only the carry form touches a flag.
// - Bit AND replaces carry with carry AND the bit, or carry AND the inverted bit, in two cycles.
// - Bit OR replaces carry with carry OR the bit, or carry OR the inverted bit, in two cycles.
// - The stack pointer is read/write at 0x81 and resets to 0x07.
// - The data pointer low byte sits at 0x82 and high byte at 0x83, both resetting to zero.
// - The idle mode select register is read/write at 0x87 and resets to zero.
// - Primary operand at 0xE0 and second operand at 0xF0 are read/write and reset to zero.
module csbc_core (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic op_valid_i,
  input wire csbc_pkg::csbc_op_e op_code_i,
  input wire logic [7:0] op_addr_i,
  output logic op_ready_o,
  output logic op_done_o,
  output logic [7:0] mem_addr_o,
  output logic mem_sfr_o,
  output logic mem_re_o,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic carry_flag_o,
  output logic [7:0] stack_pointer_o,
  output logic [15:0] data_pointer_o,
  output logic [7:0] idle_select_o,
  output logic [7:0] primary_operand_o,
  output logic [7:0] second_operand_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  csbc_pkg::csbc_state_e state_reg;
  csbc_pkg::csbc_op_e op_reg;
  logic [7:0] src_addr_reg;
  logic src_sfr_reg;
  logic src_local_reg;
  logic [7:0] src_local_data_reg;
  logic [7:0] dest_addr_reg;
  logic [2:0] bit_sel_reg;
  logic [7:0] stack_pointer_reg;
  logic [7:0] data_pointer_low_reg;
  logic [7:0] data_pointer_high_reg;
  logic [7:0] idle_select_reg;
  logic [7:0] primary_operand_reg;
  logic [7:0] second_operand_reg;
  logic carry_flag_reg;
  logic op_ready_reg;
  logic op_done_reg;
  logic [7:0] mem_addr_reg;
  logic mem_sfr_reg;
  logic mem_re_reg;
  logic mem_we_reg;
  logic [7:0] mem_wdata_reg;
  logic [7:0] reg_rdata_reg;

  logic accept;
  logic fetch;
  logic is_long;
  logic is_bit_op;
  logic [7:0] bit_byte_addr;
  logic bit_sfr;
  logic [7:0] fetch_data;
  logic [7:0] unit_byte;
  logic unit_carry;
  logic eng_wr;
  logic [7:0] eng_wr_addr;
  logic eng_wr_sfr;
  logic [7:0] eng_wr_data;
  logic eng_wr_local;
  logic carry_dest;
  logic [7:0] accept_local_data;
  logic accept_local;

  // Only the special function space holds registers owned here
  function automatic logic is_local(input logic [7:0] addr, input logic sfr);
    is_local = sfr && (addr == `CSBC_STACK_POINTER_ADDR ||
                       addr == `CSBC_DATA_POINTER_LOW_ADDR ||
                       addr == `CSBC_DATA_POINTER_HIGH_ADDR ||
                       addr == `CSBC_IDLE_SELECT_ADDR ||
                       addr == `CSBC_CORE_STATUS_ADDR ||
                       addr == `CSBC_PRIMARY_OPERAND_ADDR ||
                       addr == `CSBC_SECOND_OPERAND_ADDR);
  endfunction

  function automatic logic [7:0] local_read(input logic [7:0] addr);
    local_read = 8'h00;
    unique case (addr)
      `CSBC_STACK_POINTER_ADDR: local_read = stack_pointer_reg;
      `CSBC_DATA_POINTER_LOW_ADDR: local_read = data_pointer_low_reg;
      `CSBC_DATA_POINTER_HIGH_ADDR: local_read = data_pointer_high_reg;
      `CSBC_IDLE_SELECT_ADDR: local_read = idle_select_reg;
      `CSBC_CORE_STATUS_ADDR: begin
        local_read[`CSBC_STATUS_CARRY_BIT] = carry_flag_reg;
        local_read[`CSBC_STATUS_BUSY_BIT] = ~op_ready_reg;
      end
      `CSBC_PRIMARY_OPERAND_ADDR: local_read = primary_operand_reg;
      `CSBC_SECOND_OPERAND_ADDR: local_read = second_operand_reg;
      default: local_read = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  assign accept = (state_reg == csbc_pkg::CSBC_ST_READY) && op_valid_i && op_ready_reg;
  assign fetch = (state_reg == csbc_pkg::CSBC_ST_FETCH);

  always_comb begin
    is_bit_op = 1'b1;
    unique case (op_code_i)
      csbc_pkg::CSBC_IDLE_OP,
      csbc_pkg::CSBC_PUSH_OP,
      csbc_pkg::CSBC_POP_OP,
      csbc_pkg::CSBC_CLEAR_OP_C,
      csbc_pkg::CSBC_SET_BIT_OP_C,
      csbc_pkg::CSBC_COMPLEMENT_OP_C: is_bit_op = 1'b0;
      default: is_bit_op = 1'b1;
    endcase
    // Carry-only and idle forms finish at once; all others need a fetch cycle
    is_long = is_bit_op || op_code_i == csbc_pkg::CSBC_PUSH_OP ||
              op_code_i == csbc_pkg::CSBC_POP_OP;
  end

  // Bits 0x00-0x7F live in the RAM bit area, the rest in SFRs whose address ends in 0 or 8
  always_comb begin
    if (op_addr_i[`CSBC_SFR_SPACE_BIT]) begin
      bit_byte_addr = {op_addr_i[7:3], 3'b000};
      bit_sfr = 1'b1;
    end else begin
      bit_byte_addr = `CSBC_BIT_AREA_BASE + {4'h0, op_addr_i[6:3]};
      bit_sfr = 1'b0;
    end
  end

  always_comb begin
    accept_local = 1'b0;
    accept_local_data = 8'h00;
    if (op_code_i == csbc_pkg::CSBC_PUSH_OP) begin
      accept_local = is_local(op_addr_i, op_addr_i[`CSBC_SFR_SPACE_BIT]);
      accept_local_data = local_read(op_addr_i);
    end else if (is_bit_op) begin
      accept_local = is_local(bit_byte_addr, bit_sfr);
      accept_local_data = local_read(bit_byte_addr);
    end
  end

  // ****************************************************************
  // Engine sequencing
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= csbc_pkg::CSBC_ST_READY;
      op_reg <= csbc_pkg::CSBC_IDLE_OP;
      src_addr_reg <= 8'h00;
      src_sfr_reg <= 1'b0;
      src_local_reg <= 1'b0;
      src_local_data_reg <= 8'h00;
      dest_addr_reg <= 8'h00;
      bit_sel_reg <= 3'h0;
      op_ready_reg <= 1'b0;
      op_done_reg <= 1'b0;
    end else begin
      op_ready_reg <= 1'b1;
      op_done_reg <= 1'b0;
      if (accept) begin
        op_reg <= op_code_i;
        bit_sel_reg <= op_addr_i[2:0];
        dest_addr_reg <= op_addr_i;
        src_local_reg <= accept_local;
        src_local_data_reg <= accept_local_data;
        if (op_code_i == csbc_pkg::CSBC_POP_OP) begin
          src_addr_reg <= stack_pointer_reg;
          src_sfr_reg <= 1'b0;
        end else if (op_code_i == csbc_pkg::CSBC_PUSH_OP) begin
          src_addr_reg <= op_addr_i;
          src_sfr_reg <= op_addr_i[`CSBC_SFR_SPACE_BIT];
        end else begin
          src_addr_reg <= bit_byte_addr;
          src_sfr_reg <= bit_sfr;
        end
        if (is_long) begin
          state_reg <= csbc_pkg::CSBC_ST_FETCH;
          op_ready_reg <= 1'b0;
        end else begin
          op_done_reg <= 1'b1;
        end
      end else if (fetch) begin
        state_reg <= csbc_pkg::CSBC_ST_READY;
        op_done_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Fetch cycle datapath
  // ****************************************************************
  assign fetch_data = src_local_reg ? src_local_data_reg : mem_rdata_i;

  csbc_bit_unit u_bit_unit (
    .op_i(op_reg),
    .byte_i(fetch_data),
    .bit_sel_i(bit_sel_reg),
    .carry_i(carry_flag_reg),
    .byte_o(unit_byte),
    .carry_o(unit_carry)
  );

  always_comb begin
    eng_wr = 1'b0;
    eng_wr_addr = src_addr_reg;
    eng_wr_sfr = src_sfr_reg;
    eng_wr_data = unit_byte;
    carry_dest = 1'b0;
    if (fetch) begin
      unique case (op_reg)
        csbc_pkg::CSBC_PUSH_OP: begin
          eng_wr = 1'b1;
          eng_wr_addr = stack_pointer_reg;
          eng_wr_sfr = 1'b0;
          eng_wr_data = fetch_data;
        end
        csbc_pkg::CSBC_POP_OP: begin
          eng_wr = 1'b1;
          eng_wr_addr = dest_addr_reg;
          eng_wr_sfr = dest_addr_reg[`CSBC_SFR_SPACE_BIT];
          eng_wr_data = fetch_data;
        end
        csbc_pkg::CSBC_MOVE_OP_BIT_C,
        csbc_pkg::CSBC_CLEAR_OP_BIT,
        csbc_pkg::CSBC_SET_BIT_OP_BIT,
        csbc_pkg::CSBC_COMPLEMENT_OP_BIT: eng_wr = 1'b1;
        csbc_pkg::CSBC_MOVE_OP_C_BIT,
        csbc_pkg::CSBC_AND_LOGIC_OP_BIT,
        csbc_pkg::CSBC_AND_LOGIC_OP_NBIT,
        csbc_pkg::CSBC_OR_LOGIC_OP_BIT,
        csbc_pkg::CSBC_OR_LOGIC_OP_NBIT: carry_dest = 1'b1;
        default: eng_wr = 1'b0;
      endcase
    end
    eng_wr_local = eng_wr && is_local(eng_wr_addr, eng_wr_sfr);
  end

  // ****************************************************************
  // Memory port
  // ****************************************************************
  // Read is issued the cycle after acceptance; the write lands one cycle after the fetch
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mem_addr_reg <= 8'h00;
      mem_sfr_reg <= 1'b0;
      mem_re_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
    end else begin
      mem_re_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      if (accept && is_long && !accept_local) begin
        mem_re_reg <= 1'b1;
        if (op_code_i == csbc_pkg::CSBC_POP_OP) begin
          mem_addr_reg <= stack_pointer_reg;
          mem_sfr_reg <= 1'b0;
        end else if (op_code_i == csbc_pkg::CSBC_PUSH_OP) begin
          mem_addr_reg <= op_addr_i;
          mem_sfr_reg <= op_addr_i[`CSBC_SFR_SPACE_BIT];
        end else begin
          mem_addr_reg <= bit_byte_addr;
          mem_sfr_reg <= bit_sfr;
        end
      end else if (eng_wr && !eng_wr_local) begin
        mem_we_reg <= 1'b1;
        mem_addr_reg <= eng_wr_addr;
        mem_sfr_reg <= eng_wr_sfr;
        mem_wdata_reg <= eng_wr_data;
      end
    end
  end

  // ****************************************************************
  // Stack pointer
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      stack_pointer_reg <= `CSBC_STACK_POINTER_RST;
    end else if (eng_wr_local && eng_wr_addr == `CSBC_STACK_POINTER_ADDR) begin
      // A pop into the pointer keeps the popped byte rather than decrementing it
      stack_pointer_reg <= eng_wr_data;
    end else if (accept && op_code_i == csbc_pkg::CSBC_PUSH_OP) begin
      stack_pointer_reg <= stack_pointer_reg + 8'h01;
    end else if (fetch && op_reg == csbc_pkg::CSBC_POP_OP) begin
      stack_pointer_reg <= stack_pointer_reg - 8'h01;
    end else if (reg_we_i && reg_addr_i == `CSBC_STACK_POINTER_ADDR) begin
      stack_pointer_reg <= reg_wdata_i;
    end
  end

  // ****************************************************************
  // Data pointer and idle select
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      data_pointer_low_reg <= `CSBC_DATA_POINTER_LOW_RST;
      data_pointer_high_reg <= `CSBC_DATA_POINTER_HIGH_RST;
    end else begin
      if (eng_wr_local && eng_wr_addr == `CSBC_DATA_POINTER_LOW_ADDR) begin
        data_pointer_low_reg <= eng_wr_data;
      end else if (reg_we_i && reg_addr_i == `CSBC_DATA_POINTER_LOW_ADDR) begin
        data_pointer_low_reg <= reg_wdata_i;
      end
      if (eng_wr_local && eng_wr_addr == `CSBC_DATA_POINTER_HIGH_ADDR) begin
        data_pointer_high_reg <= eng_wr_data;
      end else if (reg_we_i && reg_addr_i == `CSBC_DATA_POINTER_HIGH_ADDR) begin
        data_pointer_high_reg <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      idle_select_reg <= `CSBC_IDLE_SELECT_RST;
    end else if (eng_wr_local && eng_wr_addr == `CSBC_IDLE_SELECT_ADDR) begin
      idle_select_reg <= eng_wr_data;
    end else if (reg_we_i && reg_addr_i == `CSBC_IDLE_SELECT_ADDR) begin
      idle_select_reg <= reg_wdata_i;
    end
  end

  // ****************************************************************
  // Operand registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      primary_operand_reg <= `CSBC_PRIMARY_OPERAND_RST;
      second_operand_reg <= `CSBC_SECOND_OPERAND_RST;
    end else begin
      if (eng_wr_local && eng_wr_addr == `CSBC_PRIMARY_OPERAND_ADDR) begin
        primary_operand_reg <= eng_wr_data;
      end else if (reg_we_i && reg_addr_i == `CSBC_PRIMARY_OPERAND_ADDR) begin
        primary_operand_reg <= reg_wdata_i;
      end
      if (eng_wr_local && eng_wr_addr == `CSBC_SECOND_OPERAND_ADDR) begin
        second_operand_reg <= eng_wr_data;
      end else if (reg_we_i && reg_addr_i == `CSBC_SECOND_OPERAND_ADDR) begin
        second_operand_reg <= reg_wdata_i;
      end
    end
  end

  // ****************************************************************
  // Carry flag
  // ****************************************************************
  // Engine updates win over a software write to the status register in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      carry_flag_reg <= `CSBC_CARRY_RST;
    end else if (accept && !is_long) begin
      carry_flag_reg <= unit_carry_short(op_code_i, carry_flag_reg);
    end else if (carry_dest) begin
      carry_flag_reg <= unit_carry;
    end else if (eng_wr_local && eng_wr_addr == `CSBC_CORE_STATUS_ADDR) begin
      carry_flag_reg <= eng_wr_data[`CSBC_STATUS_CARRY_BIT];
    end else if (reg_we_i && reg_addr_i == `CSBC_CORE_STATUS_ADDR) begin
      carry_flag_reg <= reg_wdata_i[`CSBC_STATUS_CARRY_BIT];
    end
  end

  // Carry-only forms need no operand byte, so they resolve on acceptance
  function automatic logic unit_carry_short(input csbc_pkg::csbc_op_e op, input logic c);
    unit_carry_short = c;
    if (op == csbc_pkg::CSBC_CLEAR_OP_C) begin
      unit_carry_short = 1'b0;
    end else if (op == csbc_pkg::CSBC_SET_BIT_OP_C) begin
      unit_carry_short = 1'b1;
    end else if (op == csbc_pkg::CSBC_COMPLEMENT_OP_C) begin
      unit_carry_short = ~c;
    end
  endfunction

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_re_i) begin
      reg_rdata_reg <= local_read(reg_addr_i);
    end else begin
      reg_rdata_reg <= 8'h00;
    end
  end

  assign op_ready_o = op_ready_reg;
  assign op_done_o = op_done_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_sfr_o = mem_sfr_reg;
  assign mem_re_o = mem_re_reg;
  assign mem_we_o = mem_we_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign reg_rdata_o = reg_rdata_reg;
  assign carry_flag_o = carry_flag_reg;
  assign stack_pointer_o = stack_pointer_reg;
  assign data_pointer_o = {data_pointer_high_reg, data_pointer_low_reg};
  assign idle_select_o = idle_select_reg;
  assign primary_operand_o = primary_operand_reg;
  assign second_operand_o = second_operand_reg;

endmodule

/* File: design/csbc_pkg.sv */
// Types shared by the stack and bit core
package csbc_pkg;

  typedef enum logic [3:0] {
    CSBC_IDLE_OP = 4'h0,
    CSBC_PUSH_OP = 4'h1,
    CSBC_POP_OP = 4'h2,
    CSBC_MOVE_OP_C_BIT = 4'h3,
    CSBC_MOVE_OP_BIT_C = 4'h4,
    CSBC_CLEAR_OP_C = 4'h5,
    CSBC_CLEAR_OP_BIT = 4'h6,
    CSBC_SET_BIT_OP_C = 4'h7,
    CSBC_SET_BIT_OP_BIT = 4'h8,
    CSBC_COMPLEMENT_OP_C = 4'h9,
    CSBC_COMPLEMENT_OP_BIT = 4'hA,
    CSBC_AND_LOGIC_OP_BIT = 4'hB,
    CSBC_AND_LOGIC_OP_NBIT = 4'hC,
    CSBC_OR_LOGIC_OP_BIT = 4'hD,
    CSBC_OR_LOGIC_OP_NBIT = 4'hE
  } csbc_op_e;

  typedef enum logic [1:0] {
    CSBC_ST_READY = 2'b00,
    CSBC_ST_FETCH = 2'b01
  } csbc_state_e;

endpackage

/* File: design/csbc_regs.svh */
// Register addresses, reset values, field positions and cycle counts of the stack and bit core
`ifndef CSBC_REGS_SVH
`define CSBC_REGS_SVH

// ****************************************************************
// Special function register addresses
// ****************************************************************
`define CSBC_STACK_POINTER_ADDR 8'h81
`define CSBC_DATA_POINTER_LOW_ADDR 8'h82
`define CSBC_DATA_POINTER_HIGH_ADDR 8'h83
`define CSBC_IDLE_SELECT_ADDR 8'h87
`define CSBC_CORE_STATUS_ADDR 8'h8F
`define CSBC_PRIMARY_OPERAND_ADDR 8'hE0
`define CSBC_SECOND_OPERAND_ADDR 8'hF0

// ****************************************************************
// Reset values
// ****************************************************************
`define CSBC_STACK_POINTER_RST 8'h07
`define CSBC_DATA_POINTER_LOW_RST 8'h00
`define CSBC_DATA_POINTER_HIGH_RST 8'h00
`define CSBC_IDLE_SELECT_RST 8'h00
`define CSBC_PRIMARY_OPERAND_RST 8'h00
`define CSBC_SECOND_OPERAND_RST 8'h00
`define CSBC_CARRY_RST 1'b0

// ****************************************************************
// Status fields and bit addressing
// ****************************************************************
`define CSBC_STATUS_CARRY_BIT 0
`define CSBC_STATUS_BUSY_BIT 1
`define CSBC_BIT_AREA_BASE 8'h20
`define CSBC_SFR_SPACE_BIT 7

// ****************************************************************
// Cycle counts from acceptance to done
// ****************************************************************
`define CSBC_SHORT_OP_CYCLES 1
`define CSBC_LONG_OP_CYCLES 2

`endif

/* File: design/placeholder_none.sv */
// Intentionally absent

/* File: sim/csbc_monitor.sv */
// Port checker of the stack and bit core
`timescale 1ns/10ps
module csbc_monitor (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic op_valid_i,
  input wire csbc_pkg::csbc_op_e op_code_i,
  input wire logic [7:0] op_addr_i,
  input wire logic op_ready_o,
  input wire logic op_done_o,
  input wire logic [7:0] mem_addr_o,
  input wire logic mem_sfr_o,
  input wire logic mem_we_o,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic carry_flag_o,
  input wire logic [7:0] stack_pointer_o
);
  logic taken;
  logic shrt;
  assign taken = op_valid_i && op_ready_o;
  assign shrt = op_code_i inside {csbc_pkg::CSBC_IDLE_OP, csbc_pkg::CSBC_CLEAR_OP_C,
    csbc_pkg::CSBC_SET_BIT_OP_C, csbc_pkg::CSBC_COMPLEMENT_OP_C};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // ****************************************
  // Operations and register port
  // ****************************************
  a_short_done: assert property (taken && shrt |=> op_done_o)
    else $error("short op done missing");
  a_long_done: assert property (taken && !shrt |=> !op_done_o ##1 op_done_o)
    else $error("long op done timing");
  // The fetch cycle must refuse a second op, then ready returns at once
  a_ready_gap: assert property (taken && !shrt |=> !op_ready_o ##1 op_ready_o)
    else $error("ready gap after long op wrong");
  a_push_write: assert property (taken && op_code_i == csbc_pkg::CSBC_PUSH_OP |-> ##2
    mem_we_o && !mem_sfr_o && mem_addr_o == $past(stack_pointer_o, 2) + 8'h01)
    else $error("push write wrong");
  // Pop into the pointer itself is excluded: the popped byte wins there
  a_pop_dec: assert property (taken && op_code_i == csbc_pkg::CSBC_POP_OP &&
    op_addr_i != 8'h81 |-> ##2 stack_pointer_o == $past(stack_pointer_o, 2) - 8'h01)
    else $error("pop pointer wrong");
  a_set_carry: assert property (taken && op_code_i == csbc_pkg::CSBC_SET_BIT_OP_C |=>
    carry_flag_o)
    else $error("carry not set");
  a_clear_carry: assert property (taken && op_code_i == csbc_pkg::CSBC_CLEAR_OP_C |=>
    !carry_flag_o)
    else $error("carry not cleared");
  a_invert_carry: assert property (taken && op_code_i == csbc_pkg::CSBC_COMPLEMENT_OP_C |=>
    carry_flag_o != $past(carry_flag_o))
    else $error("carry not inverted");
  a_idle_quiet: assert property (taken && op_code_i == csbc_pkg::CSBC_IDLE_OP |=>
    $stable(carry_flag_o) && $stable(stack_pointer_o) && !mem_we_o)
    else $error("idle op changed state");
  a_pointer_read: assert property (reg_re_i && reg_addr_i == 8'h81 |=>
    reg_rdata_o == $past(stack_pointer_o))
    else $error("pointer read wrong");
  a_rdata_quiet: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not cleared");
  c_push: cover property (taken && op_code_i == csbc_pkg::CSBC_PUSH_OP);
  c_pop: cover property (taken && op_code_i == csbc_pkg::CSBC_POP_OP);
  c_read: cover property (reg_re_i && reg_addr_i == 8'h81);
endmodule

/* File: sim/tb_csbc_core.sv */
// Self-checking bench of the stack and bit core
`timescale 1ns/10ps
module tb_csbc_core;
  logic sys_clk_i, srst_i, op_valid_i, reg_we_i, reg_re_i;
  csbc_pkg::csbc_op_e op_code_i;
  logic [7:0] op_addr_i, reg_addr_i, reg_wdata_i, mem_rdata_i, mem_addr_o, mem_wdata_o;
  logic op_ready_o, op_done_o, mem_sfr_o, mem_re_o, mem_we_o, carry_flag_o;
  logic [7:0] reg_rdata_o, stack_pointer_o, idle_select_o, primary_operand_o, second_operand_o;
  logic [15:0] data_pointer_o;
  logic [7:0] mem [256];
  logic [7:0] ra [6] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'he0, 8'hf0};
  logic [7:0] rv [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int error_cnt = 0;
  int checked = 0;
  csbc_core i_dut (.sys_clk_i, .srst_i, .op_valid_i, .op_code_i, .op_addr_i, .op_ready_o,
    .op_done_o, .mem_addr_o, .mem_sfr_o, .mem_re_o, .mem_we_o, .mem_wdata_o, .mem_rdata_i,
    .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .carry_flag_o,
    .stack_pointer_o, .data_pointer_o, .idle_select_o, .primary_operand_o, .second_operand_o);
  // Off the read strobe the bus shows the inverted byte, so a late sample cannot pass
  assign mem_rdata_i = mem_re_o ? mem[mem_addr_o] : ~mem[mem_addr_o];
  always @(posedge sys_clk_i) begin
    if (mem_we_o) begin
      mem[mem_addr_o] <= mem_wdata_o;
    end
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  // Checks the acceptance-to-done count and the carry afterwards
  task automatic run_op(input csbc_pkg::csbc_op_e c, input logic [7:0] a, input logic ec);
    int n;
    @(posedge sys_clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_addr_i <= a;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      n++;
      #1;
    end while (op_done_o !== 1'b1 && n < 6);
    chk(n, (c inside {csbc_pkg::CSBC_IDLE_OP, csbc_pkg::CSBC_CLEAR_OP_C,
      csbc_pkg::CSBC_SET_BIT_OP_C, csbc_pkg::CSBC_COMPLEMENT_OP_C}) ? 1 : 2);
    chk(carry_flag_o, ec);
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    error_cnt++;
    test_done;
  end
  initial begin
    {srst_i, op_valid_i, reg_we_i, reg_re_i} = 4'h8;
    {op_addr_i, reg_addr_i, reg_wdata_i} = 24'h00_0000;
    op_code_i = csbc_pkg::CSBC_IDLE_OP;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8'h21] = 8'h08;
    mem[8'h40] = 8'h77;
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(8'h90, 8'h00);
    foreach (ra[i]) wr(ra[i], 8'ha5 ^ ra[i]);
    foreach (ra[i]) rd(ra[i], 8'ha5 ^ ra[i]);
    chk(data_pointer_o, 16'h2627);
    chk({primary_operand_o, second_operand_o}, 16'h4555);
    chk(idle_select_o, 8'h22);
    wr(8'h81, 8'h30);
    run_op(csbc_pkg::CSBC_SET_BIT_OP_C, 8'h00, 1'b1);
    run_op(csbc_pkg::CSBC_COMPLEMENT_OP_C, 8'h00, 1'b0);
    run_op(csbc_pkg::CSBC_IDLE_OP, 8'h00, 1'b0);
    run_op(csbc_pkg::CSBC_COMPLEMENT_OP_C, 8'h00, 1'b1);
    run_op(csbc_pkg::CSBC_IDLE_OP, 8'h00, 1'b1);
    run_op(csbc_pkg::CSBC_CLEAR_OP_C, 8'h00, 1'b0);
    run_op(csbc_pkg::CSBC_OR_LOGIC_OP_BIT, 8'h0b, 1'b1);
    run_op(csbc_pkg::CSBC_AND_LOGIC_OP_NBIT, 8'h0b, 1'b0);
    run_op(csbc_pkg::CSBC_OR_LOGIC_OP_NBIT, 8'h0b, 1'b0);
    run_op(csbc_pkg::CSBC_SET_BIT_OP_C, 8'h00, 1'b1);
    run_op(csbc_pkg::CSBC_AND_LOGIC_OP_BIT, 8'h0b, 1'b1);
    run_op(csbc_pkg::CSBC_MOVE_OP_C_BIT, 8'h0c, 1'b0);
    run_op(csbc_pkg::CSBC_MOVE_OP_C_BIT, 8'h0b, 1'b1);
    run_op(csbc_pkg::CSBC_MOVE_OP_BIT_C, 8'h0c, 1'b1);
    run_op(csbc_pkg::CSBC_CLEAR_OP_BIT, 8'h0b, 1'b1);
    run_op(csbc_pkg::CSBC_SET_BIT_OP_BIT, 8'h0d, 1'b1);
    run_op(csbc_pkg::CSBC_COMPLEMENT_OP_BIT, 8'h0c, 1'b1);
    chk(mem[8'h21], 8'h20);
    // Bit in a local register: no memory strobe, the register itself changes
    run_op(csbc_pkg::CSBC_SET_BIT_OP_BIT, 8'he1, 1'b1);
    chk(primary_operand_o, 8'h47);
    run_op(csbc_pkg::CSBC_PUSH_OP, 8'h40, 1'b1);
    chk({stack_pointer_o, mem[8'h31]}, 16'h3177);
    run_op(csbc_pkg::CSBC_POP_OP, 8'h50, 1'b1);
    chk({stack_pointer_o, mem[8'h50]}, 16'h3077);
    rd(8'h81, 8'h30);
    rd(8'h8f, 8'h01);
    test_done;
  end
endmodule
bind csbc_core csbc_monitor i_mon (.sys_clk_i, .srst_i, .op_valid_i, .op_code_i, .op_addr_i,
  .op_ready_o, .op_done_o, .mem_addr_o, .mem_sfr_o, .mem_we_o, .reg_re_i, .reg_addr_i,
  .reg_rdata_o, .carry_flag_o, .stack_pointer_o);
